// *** verilog/modulator_carrier_select.v ***
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "carrier_select_defs.vh"

module modulator_carrier_select (
  input wire clk,
  input wire nrst,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire carrier_input_pin_one,
  input wire carrier_input_pin_two,
  input wire ref_clock_in,
  input wire [`PWM_UNITS-1:0] pwm_in,
  input wire modulator_signal,
  output reg modulated_out,
  output wire [`PWM_UNITS-1:0] pwm_pin_drive_off
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // every carrier source is off-domain, so all pass two flops
  localparam SYN_W = 4 + `PWM_UNITS;
  reg [SYN_W-1:0] syn1_r;
  reg [SYN_W-1:0] syn2_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syn1_r <= {SYN_W{1'b0}};
      syn2_r <= {SYN_W{1'b0}};
    end else begin
      syn1_r <= {pwm_in, modulator_signal, ref_clock_in, carrier_input_pin_two, carrier_input_pin_one};
      syn2_r <= syn1_r;
    end
  end

  wire s_pin_one = syn2_r[0];
  wire s_pin_two = syn2_r[1];
  wire s_ref = syn2_r[2];
  wire s_mod_in = syn2_r[3];
  wire [`PWM_UNITS-1:0] s_pwm = syn2_r[SYN_W-1:4];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] high_carrier_control_r;
  reg [7:0] low_carrier_control_r;
  reg [7:0] modulator_control_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_carrier_control_r <= `CAR_RESET;
      low_carrier_control_r <= `CAR_RESET;
      modulator_control_r <= `MOD_RESET;
    end else if (wr) begin
      case (addr)
        `ADDR_HIGH_CARRIER_CONTROL: high_carrier_control_r <= wdata & `CAR_WRITE_MASK;
        `ADDR_LOW_CARRIER_CONTROL: low_carrier_control_r <= wdata & `CAR_WRITE_MASK;
        `ADDR_MODULATOR_CONTROL: modulator_control_r <= wdata & `MOD_WRITE_MASK;
        default: ;
      endcase
    end
  end

  wire [3:0] high_carrier_source_sel = high_carrier_control_r[`CAR_SEL_HI:`CAR_SEL_LO];
  wire high_carrier_invert = high_carrier_control_r[`CAR_INVERT_BIT];
  wire high_carrier_sync_enable = high_carrier_control_r[`CAR_SYNC_BIT];
  wire high_carrier_pin_drive_off = high_carrier_control_r[`CAR_PIN_OFF_BIT];
  wire [3:0] low_carrier_source_sel = low_carrier_control_r[`CAR_SEL_HI:`CAR_SEL_LO];
  wire low_carrier_invert = low_carrier_control_r[`CAR_INVERT_BIT];
  wire low_carrier_sync_enable = low_carrier_control_r[`CAR_SYNC_BIT];
  wire low_carrier_pin_drive_off = low_carrier_control_r[`CAR_PIN_OFF_BIT];
  wire modulator_enable = modulator_control_r[`MOD_ENABLE_BIT];
  wire modulator_data = modulator_control_r[`MOD_DATA_BIT];

  // ----------------------------------------
  // carrier paths
  // ----------------------------------------
  wire carrier_high;
  wire carrier_low;
  wire [`PWM_UNITS-1:0] high_off;
  wire [`PWM_UNITS-1:0] low_off;

  carrier_source_mux u_high (
    .sel(high_carrier_source_sel),
    .invert(high_carrier_invert),
    .pin_off(high_carrier_pin_drive_off),
    .pin_one(s_pin_one),
    .pin_two(s_pin_two),
    .ref_clock(s_ref),
    .pwm(s_pwm),
    .carrier(carrier_high),
    .pwm_pin_off(high_off)
  );

  carrier_source_mux u_low (
    .sel(low_carrier_source_sel),
    .invert(low_carrier_invert),
    .pin_off(low_carrier_pin_drive_off),
    .pin_one(s_pin_one),
    .pin_two(s_pin_two),
    .ref_clock(s_ref),
    .pwm(s_pwm),
    .carrier(carrier_low),
    .pwm_pin_off(low_off)
  );

  assign pwm_pin_drive_off = high_off | low_off;

  // ----------------------------------------
  // switching with optional sync
  // ----------------------------------------
  // modulator signal is the OR of the synchronised pin and the data bit, with no mode select;
  // the pin alone decides only while the data bit is clear
  wire mod_sig = s_mod_in | modulator_data;

  localparam ST_LOW = 1'b0;
  localparam ST_HIGH = 1'b1;
  reg state_r;
  reg state_nxt;
  reg carrier_high_d_r;
  reg carrier_low_d_r;

  wire high_fall = carrier_high_d_r & ~carrier_high;
  wire low_fall = carrier_low_d_r & ~carrier_low;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HIGH: begin
        if (!mod_sig && (!high_carrier_sync_enable || high_fall)) begin
          state_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (mod_sig && (!low_carrier_sync_enable || low_fall)) begin
          state_nxt = ST_HIGH;
        end
      end
      default: state_nxt = ST_LOW;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_LOW;
      carrier_high_d_r <= 1'b0;
      carrier_low_d_r <= 1'b0;
      modulated_out <= 1'b0;
    end else begin
      carrier_high_d_r <= carrier_high;
      carrier_low_d_r <= carrier_low;
      if (!modulator_enable) begin
        // held in low so a later enable starts from a known side
        state_r <= ST_LOW;
        modulated_out <= 1'b0;
      end else begin
        state_r <= state_nxt;
        modulated_out <= (state_nxt == ST_HIGH) ? carrier_high : carrier_low;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_HIGH_CARRIER_CONTROL: rdata <= high_carrier_control_r;
        `ADDR_LOW_CARRIER_CONTROL: rdata <= low_carrier_control_r;
        `ADDR_MODULATOR_CONTROL: rdata <= modulator_control_r | ({7'h00, modulated_out} << `MOD_OUT_BIT);
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // modulator_carrier_select

// *** verilog/carrier_select_defs.vh ***
`ifndef CARRIER_SELECT_DEFS_VH
`define CARRIER_SELECT_DEFS_VH

// ----------------------------------------
// register map (indices on the plain port)
// ----------------------------------------
`define ADDR_W 2
`define ADDR_HIGH_CARRIER_CONTROL 2'h0
`define ADDR_LOW_CARRIER_CONTROL 2'h1
`define ADDR_MODULATOR_CONTROL 2'h2

// ----------------------------------------
// carrier control fields
// ----------------------------------------
`define CAR_PIN_OFF_BIT 7
`define CAR_INVERT_BIT 6
`define CAR_SYNC_BIT 5
`define CAR_UNUSED_BIT 4
`define CAR_SEL_HI 3
`define CAR_SEL_LO 0
`define CAR_WRITE_MASK 8'hef
`define CAR_RESET 8'h00

// ----------------------------------------
// modulator control fields
// ----------------------------------------
`define MOD_ENABLE_BIT 7
`define MOD_OUT_BIT 3
`define MOD_DATA_BIT 0
`define MOD_WRITE_MASK 8'h81
`define MOD_RESET 8'h00

// ----------------------------------------
// source codes
// ----------------------------------------
`define SRC_GROUND 4'h0
`define SRC_PIN_ONE 4'h1
`define SRC_PIN_TWO 4'h2
`define SRC_REF_CLOCK 4'h3
`define SRC_PWM_ONE 4'h4
`define SRC_PWM_TWO 4'h5
`define SRC_PWM_THREE 4'h6
`define SRC_PWM_FOUR 4'h7
`define PWM_UNITS 4

`endif

// *** verilog/carrier_source_mux.v ***
`timescale 1ns/10ps
`include "carrier_select_defs.vh"

// ----------------------------------------
// one carrier path: select, invert, pin drive cut
// ----------------------------------------
module carrier_source_mux (
  input wire [3:0] sel,
  input wire invert,
  input wire pin_off,
  input wire pin_one,
  input wire pin_two,
  input wire ref_clock,
  input wire [`PWM_UNITS-1:0] pwm,
  output wire carrier,
  output wire [`PWM_UNITS-1:0] pwm_pin_off
);
  reg raw;

  always @* begin
    case (sel)
      `SRC_GROUND: raw = 1'b0;
      `SRC_PIN_ONE: raw = pin_one;
      `SRC_PIN_TWO: raw = pin_two;
      `SRC_REF_CLOCK: raw = ref_clock;
      `SRC_PWM_ONE: raw = pwm[0];
      `SRC_PWM_TWO: raw = pwm[1];
      `SRC_PWM_THREE: raw = pwm[2];
      `SRC_PWM_FOUR: raw = pwm[3];
      // reserved codes connect nothing
      default: raw = 1'b0;
    endcase
  end

  assign carrier = raw ^ invert;

  genvar i;
  generate
    for (i = 0; i < `PWM_UNITS; i = i + 1) begin : g_off
      assign pwm_pin_off[i] = pin_off & (sel == (`SRC_PWM_ONE + i));
    end
  endgenerate
endmodule // carrier_source_mux

// *** bench/carrier_select_monitor.sv ***
`timescale 1ns/10ps
`include "carrier_select_defs.vh"
module carrier_select_monitor (
  input wire clk,
  input wire nrst,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire modulated_out,
  input wire [`PWM_UNITS-1:0] pwm_pin_drive_off
);
  // ----------------------------------------
  // shadow of the carrier and enable settings
  // ----------------------------------------
  reg [7:0] hi_r;
  reg [7:0] lo_r;
  reg en_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      en_r <= 1'b0;
    end else if (wr) begin
      if (addr == 2'h0) hi_r <= wdata;
      if (addr == 2'h1) lo_r <= wdata;
      if (addr == 2'h2) en_r <= wdata[7];
    end
  end
  wire hi_cut = hi_r[7] && hi_r[3:2] == 2'h1;
  wire lo_cut = lo_r[7] && lo_r[3:2] == 2'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_bit4; $past(rd) && $past(addr) < 2'h2 |-> !rdata[4]; endproperty
  a_bit4: assert property (p_bit4) else $error("unused carrier bit read as one");
  property p_unmapped; $past(rd) && $past(addr) == 2'h3 |-> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");
  property p_off; !en_r [*4] |-> !modulated_out; endproperty
  a_off: assert property (p_off) else $error("output while disabled");
  property p_cut_hi; hi_cut |-> pwm_pin_drive_off[hi_r[1:0]]; endproperty
  a_cut_hi: assert property (p_cut_hi) else $error("high pin drive not cut");
  property p_cut_lo; lo_cut |-> pwm_pin_drive_off[lo_r[1:0]]; endproperty
  a_cut_lo: assert property (p_cut_lo) else $error("low pin drive not cut");
  property p_no_cut; !hi_cut && !lo_cut |-> pwm_pin_drive_off == 4'h0; endproperty
  a_no_cut: assert property (p_no_cut) else $error("pin drive cut unasked");
  property p_rst; $rose(nrst) |-> !modulated_out && pwm_pin_drive_off == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs active out of reset");
endmodule // carrier_select_monitor
bind modulator_carrier_select carrier_select_monitor mon (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .modulated_out(modulated_out), .pwm_pin_drive_off(pwm_pin_drive_off));

// *** bench/carrier_sources.sv ***
`timescale 1ns/10ps
// static levels keep the expected output free of sampling races
module carrier_sources (
  input wire [6:0] lv,
  output wire pin_one,
  output wire pin_two,
  output wire ref_clk,
  output wire [3:0] pwm
);
  assign {pwm, ref_clk, pin_two, pin_one} = lv;
endmodule // carrier_sources

// *** bench/tb_modulator_carrier_select.sv ***
`timescale 1ns/10ps
module tb_modulator_carrier_select;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [1:0] addr = 2'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg msig = 1'b0;
  reg [6:0] lv = 7'h35;
  wire [7:0] rdata;
  wire p1, p2, rc, out;
  wire [3:0] pwm, cut;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer c, i;
  always #5 clk = ~clk;
  carrier_sources src (.lv(lv), .pin_one(p1), .pin_two(p2), .ref_clk(rc), .pwm(pwm));
  modulator_carrier_select DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .carrier_input_pin_one(p1), .carrier_input_pin_two(p2), .ref_clock_in(rc), .pwm_in(pwm),
    .modulator_signal(msig), .modulated_out(out), .pwm_pin_drive_off(cut));
  task chk(input [7:0] e, input [7:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr_reg(input [1:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [1:0] a, input [7:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(e, rdata);
  endtask
  task w_out(input integer n, input e);
    repeat (n) @(posedge clk);
    #1 chk({7'h0, e}, {7'h0, out});
  endtask
  task t_regs;
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h1, 8'h00);
    rd_reg(2'h2, 8'h00);
    wr_reg(2'h0, 8'hff);
    rd_reg(2'h0, 8'hef);
    wr_reg(2'h1, 8'h10);
    rd_reg(2'h1, 8'h00);
    wr_reg(2'h3, 8'hff);
    rd_reg(2'h3, 8'h00);
    wr_reg(2'h0, 8'h00);
  endtask
  // side 1 drives the high carrier, 0 the low one; the last pass tries a reserved code uninverted
  task t_select(input side);
    for (c = 0; c < 17; c = c + 1) begin
      wr_reg({1'b0, ~side}, {1'b0, c[0], 2'h0, c[4:1]});
      msig <= side;
      w_out(4, (c[4] ? 1'b0 : {lv, 1'b0} >> c[3:1]) ^ c[0]);
    end
  endtask
  task t_pin_off;
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(2'h0, 8'h84 + i);
      #1 chk(8'h01 << i, {4'h0, cut});
      wr_reg(2'h0, 8'h04 + i);
      wr_reg(2'h1, 8'h84 + i);
      #1 chk(8'h01 << i, {4'h0, cut});
      wr_reg(2'h1, 8'h03);
      #1 chk(8'h00, {4'h0, cut});
    end
  endtask
  task t_sync;
    lv <= 7'h01;
    wr_reg(2'h0, 8'h21);
    wr_reg(2'h1, 8'h03);
    msig <= 1'b1;
    w_out(5, 1'b1);
    rd_reg(2'h2, 8'h88);
    wr_reg(2'h2, 8'h00);
    w_out(4, 1'b0);
    wr_reg(2'h2, 8'h80);
    w_out(4, 1'b1);
    msig <= 1'b0;
    w_out(6, 1'b1);
    // high carrier falls while the low one rises: only a switch shows a one
    lv <= 7'h04;
    w_out(5, 1'b1);
    wr_reg(2'h0, 8'h03);
    wr_reg(2'h1, 8'h21);
    lv <= 7'h01;
    w_out(5, 1'b1);
    msig <= 1'b1;
    w_out(6, 1'b1);
    lv <= 7'h04;
    w_out(5, 1'b1);
  endtask
  task t_reset;
    wr_reg(2'h0, 8'h44);
    wr_reg(2'h1, 8'hc5);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(8'h00, {4'h0, cut});
    rd_reg(2'h0, 8'h00);
    rd_reg(2'h1, 8'h00);
    rd_reg(2'h2, 8'h00);
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    wr_reg(2'h2, 8'h80);
    t_select(1'b1);
    wr_reg(2'h0, 8'h00);
    t_select(1'b0);
    t_pin_off;
    t_sync;
    t_reset;
    close_out;
  end
endmodule // tb_modulator_carrier_select
